// ===== hdl/aes_pkg.sv
// Constants and types for the rule-table entry staging registers
package aes_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Management byte addresses
  localparam logic [7:0] AES_ADDR_IND_CTRL = 8'h6e;
  localparam logic [7:0] AES_ADDR_IND_OFS  = 8'h6f;
  localparam logic [7:0] AES_ADDR_IND_DATA = 8'ha0;

  ////////////////////////////////////////////////////////////////////////////////
  // Indirect control fields
  localparam logic [2:0] AES_SPACE_ACL     = 3'h2;
  localparam int         AES_SPACE_MSB     = 7;
  localparam int         AES_SPACE_LSB     = 5;
  localparam int         AES_PORT_MSB      = 3;
  localparam logic [3:0] AES_PORT_MIN      = 4'h1;
  localparam logic [3:0] AES_PORT_MAX      = 4'h5;

  ////////////////////////////////////////////////////////////////////////////////
  // Staging offsets
  localparam logic [7:0] AES_OFS_ENTRY_END = 8'h0d;
  localparam logic [7:0] AES_OFS_MASK_HI   = 8'h0c;
  localparam logic [7:0] AES_OFS_MASK_LO   = 8'h0d;
  localparam logic [7:0] AES_OFS_BSEL_HI   = 8'h10;
  localparam logic [7:0] AES_OFS_BSEL_LO   = 8'h11;
  localparam logic [7:0] AES_OFS_ACC       = 8'h12;

  ////////////////////////////////////////////////////////////////////////////////
  // Access-control byte fields
  localparam int         AES_ACC_WDONE_BIT = 6;
  localparam int         AES_ACC_RDONE_BIT = 5;
  localparam int         AES_ACC_DIR_BIT   = 4;
  localparam int         AES_ACC_IDX_MSB   = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and last staging byte index
  localparam logic [7:0]  AES_RST_BYTE     = 8'h00;
  localparam logic [13:0] AES_RST_BSEL     = 14'h0000;
  localparam logic        AES_RST_DONE     = 1'b1;
  localparam logic        AES_RST_DIR      = 1'b0;
  localparam logic [3:0]  AES_RST_INDEX    = 4'h0;
  localparam logic [3:0]  AES_LAST_BYTE    = 4'hd;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aes_req_s;

  typedef enum logic [1:0] {AES_IDLE, AES_RUN, AES_LAST} aes_state_e;

endpackage : aes_pkg

// ===== hdl/aes_mem.sv
// Byte-wide rule table storage with registered read data
module aes_mem #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  // Table contents need no reset; software writes entries before use
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[addr_i] <= wdata_i;
    end
    rdata_o <= mem_r[addr_i];
  end

endmodule : aes_mem

// ===== hdl/aes_regs.sv
// Per-port rule-table entry staging registers and transfer engine
module aes_regs
  import aes_pkg::*;
#(
  parameter int PORTS   = 5,
  parameter int ENTRIES = 16,
  parameter int NBYTES  = 14
) (
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  input  wire aes_req_s           req_i,
  output logic      [7:0]         reg_rdata_o,
  output logic                    reg_rvalid_o,
  output logic                    busy_o,
  output logic      [PORTS*16-1:0] cascade_group_mask_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0]  ctrl_r;
  logic [7:0]  ofs_r;
  logic [7:0]  stage_r [PORTS][NBYTES];
  logic [13:0] byte_select_mask_r [PORTS];
  logic        dir_r [PORTS];
  logic [3:0]  entry_index_r [PORTS];
  logic        wdone_r [PORTS];
  logic        rdone_r [PORTS];

  aes_state_e  state_r;
  logic [2:0]  eng_port_r;
  logic        eng_dir_r;
  logic [3:0]  eng_entry_r;
  logic [3:0]  cnt_r;
  logic        cap_vld_r;
  logic [3:0]  cap_idx_r;
  logic [7:0]  mem_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic byte_on(input logic [13:0] m, input logic [3:0] b);
    byte_on = m[4'(AES_LAST_BYTE - b)];
  endfunction : byte_on

  ////////////////////////////////////////////////////////////////////////////////
  // Decode
  wire [3:0] port_num  = ctrl_r[AES_PORT_MSB:0];
  wire       space_ok  = (ctrl_r[AES_SPACE_MSB:AES_SPACE_LSB] == AES_SPACE_ACL);
  wire       port_ok   = (port_num >= AES_PORT_MIN) && (port_num <= AES_PORT_MAX);
  // Bad port leaves pidx past the arrays or wrapped onto another port, so every use is gated by sel_ok
  wire       sel_ok    = space_ok && port_ok;
  wire [2:0] pidx      = 3'(port_num - AES_PORT_MIN);
  wire       data_wr   = req_i.wr && (req_i.addr == AES_ADDR_IND_DATA) && sel_ok;
  wire       is_entry  = (ofs_r <= AES_OFS_ENTRY_END);
  wire       start     = data_wr && (ofs_r == AES_OFS_ACC) && (state_r == AES_IDLE);
  wire       cur_on    = byte_on(byte_select_mask_r[eng_port_r], cnt_r);
  wire       mem_we    = (state_r == AES_RUN) && eng_dir_r && cur_on;
  wire [10:0] mem_addr = {eng_port_r, eng_entry_r, cnt_r};
  wire [7:0] mem_wdata = stage_r[eng_port_r][cnt_r];

  // Bit 7 is reserved and reads zero
  wire [7:0] acc_byte  = {1'b0,
                          wdone_r[pidx],
                          rdone_r[pidx],
                          dir_r[pidx],
                          entry_index_r[pidx]};
  wire [7:0] data_rd   = !sel_ok                   ? 8'h00 :
                         is_entry                  ? stage_r[pidx][ofs_r[3:0]] :
                         (ofs_r == AES_OFS_BSEL_HI) ? {2'b00, byte_select_mask_r[pidx][13:8]} :
                         (ofs_r == AES_OFS_BSEL_LO) ? byte_select_mask_r[pidx][7:0] :
                         (ofs_r == AES_OFS_ACC)     ? acc_byte : 8'h00;
  wire [7:0] rd_mux    = (req_i.addr == AES_ADDR_IND_CTRL) ? ctrl_r :
                         (req_i.addr == AES_ADDR_IND_OFS)  ? ofs_r  :
                         (req_i.addr == AES_ADDR_IND_DATA) ? data_rd : 8'h00;

  // Cascade set per port is the staged mask bytes; bit n selects rule entry n
  for (genvar g = 0; g < PORTS; g++) begin : g_mask
    assign cascade_group_mask_o[g*16 +: 16] =
      {stage_r[g][AES_OFS_MASK_HI[3:0]], stage_r[g][AES_OFS_MASK_LO[3:0]]};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus side
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_r       <= AES_RST_BYTE;
      ofs_r        <= AES_RST_BYTE;
      reg_rdata_o  <= AES_RST_BYTE;
      reg_rvalid_o <= 1'b0;
    end else begin
      // Same-cycle read returns the value from before the write
      reg_rvalid_o <= req_i.rd;
      if (req_i.rd) begin
        reg_rdata_o <= rd_mux;
      end
      if (req_i.wr && req_i.addr == AES_ADDR_IND_CTRL) begin
        ctrl_r <= req_i.wdata;
      end
      if (req_i.wr && req_i.addr == AES_ADDR_IND_OFS) begin
        ofs_r <= req_i.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Staging and per-port control
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int p = 0; p < PORTS; p++) begin
        for (int b = 0; b < NBYTES; b++) begin
          stage_r[p][b] <= AES_RST_BYTE;
        end
        byte_select_mask_r[p] <= AES_RST_BSEL;
        dir_r[p]              <= AES_RST_DIR;
        entry_index_r[p]      <= AES_RST_INDEX;
        wdone_r[p]            <= AES_RST_DONE;
        rdone_r[p]            <= AES_RST_DONE;
      end
    end else begin
      if (data_wr && is_entry) begin
        stage_r[pidx][ofs_r[3:0]] <= req_i.wdata;
      end
      if (data_wr && ofs_r == AES_OFS_BSEL_HI) begin
        byte_select_mask_r[pidx][13:8] <= req_i.wdata[5:0];
      end
      if (data_wr && ofs_r == AES_OFS_BSEL_LO) begin
        byte_select_mask_r[pidx][7:0] <= req_i.wdata;
      end
      // Access byte is taken only while idle so a live transfer is never retargeted
      if (start) begin
        dir_r[pidx]         <= req_i.wdata[AES_ACC_DIR_BIT];
        entry_index_r[pidx] <= req_i.wdata[AES_ACC_IDX_MSB:0];
        if (req_i.wdata[AES_ACC_DIR_BIT]) begin
          wdone_r[pidx] <= 1'b0;
        end else begin
          rdone_r[pidx] <= 1'b0;
        end
      end
      // Engine has priority over software on the same staging byte
      if (cap_vld_r) begin
        stage_r[eng_port_r][cap_idx_r] <= mem_rdata;
      end
      // Done bits clear only at start and set only in LAST, so never together
      if (state_r == AES_LAST) begin
        if (eng_dir_r) begin
          wdone_r[eng_port_r] <= 1'b1;
        end else begin
          rdone_r[eng_port_r] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transfer engine: one byte per cycle, read data lands one cycle later
  // All 14 bytes are stepped whatever the mask; fixed length keeps polling simple
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r     <= AES_IDLE;
      eng_port_r  <= 3'h0;
      eng_dir_r   <= 1'b0;
      eng_entry_r <= 4'h0;
      cnt_r       <= 4'h0;
      cap_vld_r   <= 1'b0;
      cap_idx_r   <= 4'h0;
      busy_o      <= 1'b0;
    end else begin
      cap_vld_r <= (state_r == AES_RUN) && !eng_dir_r && cur_on;
      cap_idx_r <= cnt_r;
      case (state_r)
        AES_IDLE: begin
          if (start) begin
            state_r     <= AES_RUN;
            eng_port_r  <= pidx;
            eng_dir_r   <= req_i.wdata[AES_ACC_DIR_BIT];
            eng_entry_r <= req_i.wdata[AES_ACC_IDX_MSB:0];
            cnt_r       <= 4'h0;
            busy_o      <= 1'b1;
          end
        end
        AES_RUN: begin
          if (cnt_r == AES_LAST_BYTE) begin
            state_r <= AES_LAST;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        AES_LAST: begin
          state_r <= AES_IDLE;
          busy_o  <= 1'b0;
        end
        default: begin
          state_r <= AES_IDLE;
          busy_o  <= 1'b0;
        end
      endcase
    end
  end

  // Table address packs port, entry and byte; only 14 of 16 byte slots used
  aes_mem #(
    .AW (11),
    .DW (8)
  ) u_mem (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .addr_i  (mem_addr),
    .wdata_i (mem_wdata),
    .rdata_o (mem_rdata)
  );

endmodule : aes_regs

// ===== verif/aes_regs_chk.sv
// Port assertions for the staging register bank
module aes_regs_chk
  import aes_pkg::*;
#(
  parameter int PORTS = 5
) (
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire aes_req_s             req_i,
  input  wire logic [7:0]           reg_rdata_o,
  input  wire logic                 reg_rvalid_o,
  input  wire logic                 busy_o,
  input  wire logic [PORTS*16-1:0]  cascade_group_mask_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Engine owns the mask bytes while busy, so those cycles are excluded
  wire wr_other = req_i.wr && (req_i.addr != AES_ADDR_IND_DATA);
  wire rd_unmap = req_i.rd && (req_i.addr != AES_ADDR_IND_DATA)
                  && (req_i.addr != AES_ADDR_IND_CTRL) && (req_i.addr != AES_ADDR_IND_OFS);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rd_ans; req_i.rd |=> reg_rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_no_ans; !req_i.rd |=> !reg_rvalid_o; endproperty
  a_no_ans: assert property (p_no_ans) else $error("spurious read valid");
  property p_rd_hold; !req_i.rd |=> $stable(reg_rdata_o); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmap; rd_unmap |=> reg_rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_mask_rst; $rose(rstn_i) |-> cascade_group_mask_o == '0; endproperty
  a_mask_rst: assert property (p_mask_rst) else $error("mask not zero after reset");
  property p_mask_keep; (wr_other || !req_i.wr) && !busy_o |=> $stable(cascade_group_mask_o);
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("mask changed untouched");
  property p_busy_len; $rose(busy_o) |-> busy_o[*8] ##1 busy_o[*7] ##1 !busy_o; endproperty
  a_busy_len: assert property (p_busy_len) else $error("transfer length wrong");
  property p_busy_start; $rose(busy_o) |-> $past(req_i.wr); endproperty
  a_busy_start: assert property (p_busy_start) else $error("transfer without write");
  c_done: cover property ($fell(busy_o));
  c_rd: cover property (req_i.rd && req_i.addr == AES_ADDR_IND_DATA);
  c_busy_wr: cover property (req_i.wr && busy_o);
endmodule : aes_regs_chk

// ===== verif/tb_aes_regs.sv
// Self-checking bench for the staging register bank
module tb_aes_regs
  import aes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  aes_req_s    req_i = '0;
  logic [7:0]  reg_rdata_o;
  logic        reg_rvalid_o;
  logic        busy_o;
  logic [79:0] cascade_group_mask_o;
  logic [7:0]  exp_q[$];
  logic [7:0]  h, l;
  int          err_total = 0;
  int          total_checks = 0;
  aes_regs dut (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .busy_o(busy_o), .cascade_group_mask_o(cascade_group_mask_o));
  always #50 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // Tasks leave the strobe up; the next call overwrites it one cycle later
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    req_i = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk_i);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd
  task automatic sel(input logic [3:0] p, input logic [7:0] o);
    bus(1'b1, AES_ADDR_IND_CTRL, {AES_SPACE_ACL, 1'b0, p});
    bus(1'b1, AES_ADDR_IND_OFS, o);
  endtask : sel
  task automatic put(input logic [3:0] p, input logic [7:0] o, input logic [7:0] d);
    sel(p, o);
    bus(1'b1, AES_ADDR_IND_DATA, d);
  endtask : put
  task automatic get(input logic [3:0] p, input logic [7:0] o, input logic [7:0] e);
    sel(p, o);
    rd(AES_ADDR_IND_DATA, e);
  endtask : get
  task automatic wait_idle;
    int n;
    n = 0;
    req_i = '0;
    @(negedge clk_i);
    while (busy_o !== 1'b0 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    cmp("idle", 16'h0000, {15'h0000, busy_o});
  endtask : wait_idle
  always @(negedge clk_i) begin
    if (reg_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) cmp("queue", 16'h0001, 16'h0000);
      else cmp("rdata", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata_o});
    end
  end
  initial begin
    #2000000;
    err_total++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(37879));
    repeat (3) @(negedge clk_i);
    rstn_i = 1'b1;
    for (logic [3:0] p = 4'h1; p <= 4'h5; p++) begin
      get(p, AES_OFS_MASK_HI, 8'h00);
      get(p, AES_OFS_BSEL_HI, 8'h00);
      get(p, AES_OFS_ACC, 8'h60);
      h = 8'($urandom);
      l = 8'($urandom);
      put(p, AES_OFS_MASK_HI, h);
      put(p, AES_OFS_MASK_LO, l);
      cmp("mask", {h, l}, cascade_group_mask_o[(p-1)*16 +: 16]);
    end
    bus(1'b1, AES_ADDR_IND_CTRL, 8'h61);
    bus(1'b1, AES_ADDR_IND_DATA, 8'h99);
    rd(AES_ADDR_IND_DATA, 8'h00);
    get(4'h6, AES_OFS_MASK_HI, 8'h00);
    rd(8'h55, 8'h00);
    for (int b = 0; b < 14; b++) put(4'h1, 8'(b), 8'(b * 8'h13 + 8'h07));
    put(4'h1, AES_OFS_BSEL_HI, 8'hff);
    rd(AES_ADDR_IND_DATA, 8'h3f);
    put(4'h1, AES_OFS_BSEL_LO, 8'hff);
    put(4'h1, AES_OFS_ACC, 8'h1f);
    bus(1'b1, AES_ADDR_IND_DATA, 8'h00);
    rd(AES_ADDR_IND_DATA, 8'h3f);
    wait_idle();
    get(4'h1, AES_OFS_ACC, 8'h7f);
    for (int b = 0; b < 14; b++) put(4'h1, 8'(b), 8'h00);
    put(4'h1, AES_OFS_BSEL_HI, 8'h15);
    put(4'h1, AES_OFS_BSEL_LO, 8'h55);
    put(4'h1, AES_OFS_ACC, 8'h0f);
    rd(AES_ADDR_IND_DATA, 8'h4f);
    wait_idle();
    for (int b = 0; b < 14; b++) get(4'h1, 8'(b), b[0] ? 8'(b * 8'h13 + 8'h07) : 8'h00);
    rd(8'h00, 8'h00);
    req_i = '0;
    repeat (3) @(negedge clk_i);
    cmp("drained", 16'h0000, 16'(exp_q.size()));
    end_sim();
  end
endmodule : tb_aes_regs
bind aes_regs aes_regs_chk #(.PORTS(PORTS)) u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .req_i(req_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .busy_o(busy_o),
  .cascade_group_mask_o(cascade_group_mask_o));
